// ==== logic/lccr_cfg_reg.sv ====
// one byte-wide configuration register with write mask
`timescale 1ns/1ps
module lccr_cfg_reg #(
  parameter logic [7:0] ADDR  = 8'h00,  // register address
  parameter logic [7:0] RST   = 8'h00,  // value after reset
  parameter logic [7:0] WMASK = 8'hff   // writable bits
) (
  input  wire logic               clk_sys_i, // system clock
  input  wire logic               rst_n_i,   // async reset, low
  input  wire lccr_pkg::lccr_acc_t acc_i,    // host access
  output logic [7:0]              q_o        // stored byte
);
  import lccr_pkg::*;

  logic [7:0] val_ff;      // stored value
  logic [7:0] nxt_val;     // next value

  // load masked byte on an addressed write
  always_comb
  begin
    nxt_val = val_ff;
    if (acc_i.wr && acc_i.addr == ADDR)
    begin
      nxt_val = acc_i.wdata & WMASK;
    end
  end

  // register the byte
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      val_ff <= RST;
    else
      val_ff <= nxt_val;
  end

  assign q_o = val_ff;
endmodule // lccr_cfg_reg

// ==== logic/lccr_pkg.sv ====
// constants and types for the lane conditioning configuration registers
package lccr_pkg;
  localparam int NUM_REGS = 6;                     // registers in this bank
  // register addresses on the management port
  localparam logic [7:0] ADDR_L0B_DEM  = 8'h35;   // lane0 port b de-emphasis
  localparam logic [7:0] ADDR_L1A_IDLE = 8'h39;   // lane1 port a idle/rate
  localparam logic [7:0] ADDR_L1_EQ    = 8'h3a;   // lane1 input equalizer
  localparam logic [7:0] ADDR_L1A_SWG  = 8'h3b;   // lane1 port a swing
  localparam logic [7:0] ADDR_L1A_DEM  = 8'h3c;   // lane1 port a de-emphasis
  localparam logic [7:0] ADDR_L1_THR   = 8'h3d;   // lane1 input idle threshold
  // register slot indices
  localparam int IDX_L0B_DEM  = 0;                 // slot of lane0 b de-emphasis
  localparam int IDX_L1A_IDLE = 1;                 // slot of idle/rate control
  localparam int IDX_L1_EQ    = 2;                 // slot of equalizer
  localparam int IDX_L1A_SWG  = 3;                 // slot of swing
  localparam int IDX_L1A_DEM  = 4;                 // slot of lane1 a de-emphasis
  localparam int IDX_L1_THR   = 5;                 // slot of threshold
  // values after reset
  localparam logic [7:0] RST_DEM  = 8'h03;         // de-emphasis default
  localparam logic [7:0] RST_IDLE = 8'h00;         // idle/rate default
  localparam logic [7:0] RST_EQ   = 8'h20;         // equalizer bypass default
  localparam logic [7:0] RST_SWG  = 8'h03;         // 600 mV swing default
  localparam logic [7:0] RST_THR  = 8'h00;         // 110/70 mV default
  // writable bits, reserved bits stay zero
  localparam logic [7:0] WM_DEM  = 8'hff;          // full byte
  localparam logic [7:0] WM_IDLE = 8'h33;          // bits 5,4,1,0
  localparam logic [7:0] WM_EQ   = 8'h3f;          // bits 5:0
  localparam logic [7:0] WM_SWG  = 8'h7f;          // bits 6:0
  localparam logic [7:0] WM_THR  = 8'h0f;          // bits 3:0
  // field positions
  localparam int POS_DEM_TYPE  = 7;                // de-emphasis style bit
  localparam int POS_IDLE_AUTO = 5;                // automatic idle bit
  localparam int POS_IDLE_SEL  = 4;                // manual mute bit
  localparam int POS_RATE_AUTO = 1;                // automatic rate bit
  localparam int POS_RATE_SEL  = 0;                // manual rate bit
  localparam int POS_EQ_EN     = 5;                // equalizer enable bit
  localparam logic [6:0] SWING_RSVD = 7'h3f;       // reserved swing code
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;   // read of unmapped address

  // per-slot tables
  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{ADDR_L0B_DEM, ADDR_L1A_IDLE,
    ADDR_L1_EQ, ADDR_L1A_SWG, ADDR_L1A_DEM, ADDR_L1_THR};
  localparam logic [7:0] REG_RST [NUM_REGS] = '{RST_DEM, RST_IDLE, RST_EQ,
    RST_SWG, RST_DEM, RST_THR};
  localparam logic [7:0] REG_WM [NUM_REGS] = '{WM_DEM, WM_IDLE, WM_EQ, WM_SWG,
    WM_DEM, WM_THR};

  // one access from the management serial engine
  typedef struct packed {
    logic       wr;     // write strobe, one cycle
    logic       rd;     // read strobe, one cycle
    logic [7:0] addr;   // register address
    logic [7:0] wdata;  // write byte
  } lccr_acc_t;

  // decoded analog conditioning settings
  typedef struct packed {
    logic       l0b_dem_type;   // lane0 b enhanced de-emphasis
    logic [6:0] l0b_dem_level;  // lane0 b de-emphasis level
    logic       l1a_dem_type;   // lane1 a enhanced de-emphasis
    logic [6:0] l1a_dem_level;  // lane1 a de-emphasis level
    logic [6:0] l1a_swing;      // lane1 a output swing code
    logic       l1a_mute;       // lane1 a in electrical idle
    logic       l1a_sd_en;      // signal detect active
    logic       l1a_rate_high;  // 5.0 to 6.4 Gbps range
    logic       l1_eq_en;       // equalizer enabled
    logic [1:0] l1_gain_stage;  // gain stage
    logic [2:0] l1_boost_level; // boost level
    logic [1:0] l1_thr_deassert;// idle deassert threshold
    logic [1:0] l1_thr_assert;  // idle assert threshold
  } lccr_cfg_t;
endpackage

// ==== logic/lccr_regs.sv ====
// lane conditioning register bank with decoded analog settings
`timescale 1ns/1ps
module lccr_regs (
  input  wire logic                clk_sys_i,     // system clock, 25 MHz
  input  wire logic                rst_n_i,       // async reset, low
  input  wire lccr_pkg::lccr_acc_t acc_i,         // access from serial engine
  input  wire logic                sig_detect_i,  // lane1 analog signal detect
  input  wire logic                rate_detect_i, // lane1 analog high rate seen
  output lccr_pkg::lccr_cfg_t      cfg_o,         // decoded settings
  output logic [7:0]               rdata_o,       // read byte
  output logic                     rvalid_o,      // read byte valid pulse
  output logic                     swing_rsvd_o   // swing holds reserved code
);
  import lccr_pkg::*;

  // all checks below run on the system clock, quiet in reset
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic [7:0] regs [NUM_REGS];   // register contents
  logic [1:0] sd_sync_ff;        // signal detect synchroniser
  logic [1:0] rd_sync_ff;        // rate detect synchroniser
  logic [1:0] nxt_sd_sync;       // next signal detect sync
  logic [1:0] nxt_rd_sync;       // next rate detect sync
  lccr_cfg_t  cfg_ff;            // registered settings
  lccr_cfg_t  nxt_cfg;           // next settings
  logic       swing_rsvd_ff;     // reserved swing flag
  logic       nxt_swing_rsvd;    // next reserved flag
  logic [7:0] rdata_ff;          // read data register
  logic [7:0] nxt_rdata;         // next read data
  logic       rvalid_ff;         // read valid register
  logic       nxt_rvalid;        // next read valid

  // auto bit picks the detector, else the manual bit
  function automatic logic auto_or_manual(input logic auto_en, input logic det,
                                          input logic man);
    auto_or_manual = auto_en ? det : man;
  endfunction

  // register slots built from the package tables
  for (genvar g = 0; g < NUM_REGS; g++)
  begin : g_reg
    lccr_cfg_reg #(
      .ADDR  (REG_ADDR[g]),
      .RST   (REG_RST[g]),
      .WMASK (REG_WM[g])
    ) u_reg (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .acc_i     (acc_i),
      .q_o       (regs[g])
    );
  end

  // detector inputs shift into two-stage synchronisers
  always_comb
  begin
    nxt_sd_sync = {sd_sync_ff[0], sig_detect_i};
    nxt_rd_sync = {rd_sync_ff[0], rate_detect_i};
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sd_sync_ff <= 2'h0;
      rd_sync_ff <= 2'h0;
    end
    else
    begin
      sd_sync_ff <= nxt_sd_sync;
      rd_sync_ff <= nxt_rd_sync;
    end
  end

  // decode register fields into analog settings
  always_comb
  begin
    nxt_cfg = '0;
    // de-emphasis style and level per output
    nxt_cfg.l0b_dem_type  = regs[IDX_L0B_DEM][POS_DEM_TYPE];
    nxt_cfg.l0b_dem_level = regs[IDX_L0B_DEM][6:0];
    nxt_cfg.l1a_dem_type  = regs[IDX_L1A_DEM][POS_DEM_TYPE];
    nxt_cfg.l1a_dem_level = regs[IDX_L1A_DEM][6:0];
    nxt_cfg.l1a_swing     = regs[IDX_L1A_SWG][6:0];
    // idle: auto follows lost signal, manual follows the mute bit
    nxt_cfg.l1a_mute = auto_or_manual(regs[IDX_L1A_IDLE][POS_IDLE_AUTO],
                                      ~sd_sync_ff[1],
                                      regs[IDX_L1A_IDLE][POS_IDLE_SEL]);
    // manual mode disables signal detect, whatever the mute bit
    nxt_cfg.l1a_sd_en = regs[IDX_L1A_IDLE][POS_IDLE_AUTO];
    // rate: auto follows detector, manual follows select bit
    nxt_cfg.l1a_rate_high = auto_or_manual(regs[IDX_L1A_IDLE][POS_RATE_AUTO],
                                           rd_sync_ff[1],
                                           regs[IDX_L1A_IDLE][POS_RATE_SEL]);
    // equalizer fields, 20h gives enable alone which is bypass
    nxt_cfg.l1_eq_en       = regs[IDX_L1_EQ][POS_EQ_EN];
    nxt_cfg.l1_gain_stage  = regs[IDX_L1_EQ][4:3];
    nxt_cfg.l1_boost_level = regs[IDX_L1_EQ][2:0];
    // idle thresholds
    nxt_cfg.l1_thr_deassert = regs[IDX_L1_THR][3:2];
    nxt_cfg.l1_thr_assert   = regs[IDX_L1_THR][1:0];
    nxt_swing_rsvd = (regs[IDX_L1A_SWG][6:0] == SWING_RSVD);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_ff        <= '0;
      swing_rsvd_ff <= 1'b0;
    end
    else
    begin
      cfg_ff        <= nxt_cfg;
      swing_rsvd_ff <= nxt_swing_rsvd;
    end
  end

  // read mux, unmapped addresses answer zero
  always_comb
  begin
    nxt_rdata  = RDATA_UNMAPPED;
    nxt_rvalid = acc_i.rd;
    if (acc_i.rd)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (acc_i.addr == REG_ADDR[i])
          nxt_rdata = regs[i];
      end
    end
    else
    begin
      nxt_rdata = rdata_ff;   // hold last byte between reads
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign cfg_o        = cfg_ff;
  assign swing_rsvd_o = swing_rsvd_ff;
  assign rdata_o      = rdata_ff;
  assign rvalid_o     = rvalid_ff;

  // checks, clocked by the defaults at the top
  logic wr_l0b_dem;   // write to lane0 b de-emphasis
  logic wr_l1a_dem;   // write to lane1 a de-emphasis
  logic wr_idle;      // write to idle/rate control
  logic wr_eq;        // write to equalizer
  logic wr_swg;       // write to swing
  logic wr_thr;       // write to threshold
  assign wr_l0b_dem = acc_i.wr && acc_i.addr == ADDR_L0B_DEM;
  assign wr_l1a_dem = acc_i.wr && acc_i.addr == ADDR_L1A_DEM;
  assign wr_idle    = acc_i.wr && acc_i.addr == ADDR_L1A_IDLE;
  assign wr_eq      = acc_i.wr && acc_i.addr == ADDR_L1_EQ;
  assign wr_swg     = acc_i.wr && acc_i.addr == ADDR_L1A_SWG;
  assign wr_thr     = acc_i.wr && acc_i.addr == ADDR_L1_THR;

  dem_type_a: assert property (wr_l1a_dem ##1 !acc_i.wr |=>
    cfg_o.l1a_dem_type == $past(acc_i.wdata[7], 2))
    else $error("de-emphasis type not taken from bit 7");
  dem_level_a: assert property (wr_l1a_dem ##1 !acc_i.wr |=>
    cfg_o.l1a_dem_level == $past(acc_i.wdata[6:0], 2))
    else $error("de-emphasis level mismatch");
  idle_auto_a: assert property (regs[IDX_L1A_IDLE][POS_IDLE_AUTO]
    |=> cfg_o.l1a_mute == !$past(sd_sync_ff[1]) && cfg_o.l1a_sd_en)
    else $error("automatic idle not following signal detect");
  idle_manual_a: assert property (!regs[IDX_L1A_IDLE][POS_IDLE_AUTO]
    |=> cfg_o.l1a_mute == $past(regs[IDX_L1A_IDLE][POS_IDLE_SEL]) && !cfg_o.l1a_sd_en)
    else $error("manual mute not applied");
  rate_auto_a: assert property (regs[IDX_L1A_IDLE][POS_RATE_AUTO]
    |=> cfg_o.l1a_rate_high == $past(rd_sync_ff[1]))
    else $error("automatic rate not following detector");
  rate_manual_a: assert property (wr_idle && !acc_i.wdata[POS_RATE_AUTO]
    ##1 !acc_i.wr |=> cfg_o.l1a_rate_high == $past(acc_i.wdata[POS_RATE_SEL], 2))
    else $error("manual rate not applied");
  eq_fields_a: assert property (wr_eq ##1 !acc_i.wr |=>
    {cfg_o.l1_eq_en, cfg_o.l1_gain_stage, cfg_o.l1_boost_level}
      == $past(acc_i.wdata[5:0], 2))
    else $error("equalizer fields mismatch");
  eq_bypass_a: assert property (regs[IDX_L1_EQ] == RST_EQ |=>
    cfg_o.l1_eq_en && cfg_o.l1_gain_stage == 2'h0 && cfg_o.l1_boost_level == 3'h0)
    else $error("bypass code not decoded");
  swing_rsvd_a: assert property (wr_swg ##1 !acc_i.wr |=>
    swing_rsvd_o == ($past(acc_i.wdata[6:0], 2) == SWING_RSVD))
    else $error("reserved swing flag wrong");
  thr_fields_a: assert property (wr_thr ##1 !acc_i.wr |=>
    cfg_o.l1_thr_deassert == $past(acc_i.wdata[3:2], 2)
      && cfg_o.l1_thr_assert == $past(acc_i.wdata[1:0], 2))
    else $error("threshold fields mismatch");
  rsvd_zero_a: assert property (regs[IDX_L1A_IDLE][7:6] == 2'h0
    && regs[IDX_L1A_IDLE][3:2] == 2'h0 && regs[IDX_L1_EQ][7:6] == 2'h0
    && regs[IDX_L1A_SWG][7] == 1'b0 && regs[IDX_L1_THR][7:4] == 4'h0)
    else $error("reserved bits not zero");
  // lane0 b de-emphasis byte lands whole in type and level
  l0b_dem_a: assert property (wr_l0b_dem ##1 !acc_i.wr |=>
    {cfg_o.l0b_dem_type, cfg_o.l0b_dem_level} == $past(acc_i.wdata, 2))
    else $error("lane0 de-emphasis byte mismatch");
  // read answers exactly one cycle after the strobe
  read_valid_a: assert property (rvalid_o == $past(acc_i.rd))
    else $error("read valid not one cycle after strobe");
  // equalizer reads back the stored byte
  read_eq_a: assert property (acc_i.rd && acc_i.addr == ADDR_L1_EQ |=>
    rdata_o == $past(regs[IDX_L1_EQ]))
    else $error("equalizer read back mismatch");

  cover_write_eq_c: cover property (wr_eq ##2 cfg_o.l1_boost_level == 3'h5);
  cover_auto_idle_c: cover property (cfg_o.l1a_sd_en && cfg_o.l1a_mute);
  cover_read_c: cover property (acc_i.rd ##1 rvalid_o);
  cover_rsvd_swing_c: cover property (swing_rsvd_o);
endmodule // lccr_regs

// ==== tb/lccr_host_model.sv ====
// host model issuing byte accesses to the conditioning register bank
`timescale 1ns/1ps
module lccr_host_model
  import lccr_pkg::*;
(
  input  wire logic           clk_sys_i, // system clock
  input  wire logic [7:0]     rdata_i,   // read byte from bank
  input  wire logic           rvalid_i,  // read valid pulse
  output lccr_pkg::lccr_acc_t acc_o      // access to bank
);
  initial acc_o = '0; // idle from time zero

  // writable bits of an address, none where unmapped
  function automatic logic [7:0] wmask(input logic [7:0] a);
    logic [7:0] m;
    m = 8'h00;
    for (int k = 0; k < NUM_REGS; k++)
      if (REG_ADDR[k] == a) m = REG_WM[k];
    return m;
  endfunction

  // one write after gap idle cycles; clean zeroes reserved bits
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input bit clean,
                           input int gap);
    repeat (gap) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    acc_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: clean ? (d & wmask(a)) : d};
    @(posedge clk_sys_i);
    acc_o <= '0;
  endtask

  // one read; answer stands just after the edge that takes the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys_i);
    acc_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys_i);
    acc_o <= '0;
    #1;
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule // lccr_host_model

// ==== tb/test_lane_conditioning_config_regs.sv ====
// self-checking bench for the lane conditioning register bank
`timescale 1ns/1ps
module test_lane_conditioning_config_regs;
  import lccr_pkg::*;
  logic       clk_sys_i = 1'b0; // 25 MHz clock
  logic       rst_n_i;          // async reset, low
  logic       sig_detect_i;     // analog signal detect
  logic       rate_detect_i;    // analog rate detect
  lccr_acc_t  acc;              // host access
  lccr_cfg_t  cfg;              // decoded settings
  logic [7:0] rdata;            // read byte
  logic       rvalid;           // read valid
  logic       swing_rsvd;       // reserved swing flag
  int         fail_count = 0;   // mismatches
  int         n_tests = 0;      // comparisons
  logic [7:0] sh [NUM_REGS];    // expected register contents
  logic [7:0] ra;               // random read address
  // address and data pairs of documented codes
  logic [15:0] codes [24] = '{16'h3501, 16'h35e8, 16'h3588, 16'h3590, 16'h35a0, 16'h3ca0,
    16'h3c88, 16'h3a2a, 16'h3a30, 16'h3a3b, 16'h3a3d, 16'h3a20, 16'h3b07, 16'h3b0f,
    16'h3b1f, 16'h3b3f, 16'h3b03, 16'h3d05, 16'h3d0a, 16'h3d0f, 16'h3910, 16'h3901,
    16'h3911, 16'h3900};

  always #20 clk_sys_i = ~clk_sys_i; // 40 ns period

  lccr_regs uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .acc_i(acc),
    .sig_detect_i(sig_detect_i), .rate_detect_i(rate_detect_i), .cfg_o(cfg),
    .rdata_o(rdata), .rvalid_o(rvalid), .swing_rsvd_o(swing_rsvd));
  lccr_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .acc_o(acc));

  // slot of a mapped address
  function automatic int idx(input logic [7:0] a);
    int k;
    k = 0;
    for (int i = 0; i < NUM_REGS; i++)
      if (REG_ADDR[i] == a) k = i;
    return k;
  endfunction

  // settings expected from shadow registers and detector levels
  function automatic lccr_cfg_t exp_cfg();
    lccr_cfg_t c;
    logic [7:0] m;
    m = sh[IDX_L1A_IDLE];
    c.l0b_dem_type    = sh[IDX_L0B_DEM][7];
    c.l0b_dem_level   = sh[IDX_L0B_DEM][6:0];
    c.l1a_dem_type    = sh[IDX_L1A_DEM][7];
    c.l1a_dem_level   = sh[IDX_L1A_DEM][6:0];
    c.l1a_swing       = sh[IDX_L1A_SWG][6:0];
    c.l1a_mute        = m[5] ? ~sig_detect_i : m[4];
    c.l1a_sd_en       = m[5];
    c.l1a_rate_high   = m[1] ? rate_detect_i : m[0];
    c.l1_eq_en        = sh[IDX_L1_EQ][5];
    c.l1_gain_stage   = sh[IDX_L1_EQ][4:3];
    c.l1_boost_level  = sh[IDX_L1_EQ][2:0];
    c.l1_thr_deassert = sh[IDX_L1_THR][3:2];
    c.l1_thr_assert   = sh[IDX_L1_THR][1:0];
    return c;
  endfunction

  // compare a byte
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // compare decoded settings
  task automatic chk_cfg(input lccr_cfg_t got, input lccr_cfg_t exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t settings got %h exp %h", $time, got, exp);
    end
  endtask

  // read and compare one register
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.read_reg(a, d, v);
    chk8(d, exp, "read data");
    chk8({7'h00, v}, 8'h01, "read valid");
  endtask

  // write a slot, then check settings two cycles on
  task automatic slot_wr(input logic [7:0] a, input logic [7:0] d, input bit clean,
                         input int gap);
    int k;
    k = idx(a);
    host.write_reg(a, d, clean, gap);
    sh[k] = d & REG_WM[k];
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk_cfg(cfg, exp_cfg());
    chk8({7'h00, swing_rsvd}, {7'h00, sh[IDX_L1A_SWG][6:0] == SWING_RSVD}, "swing flag");
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    rst_n_i = 1'b0;
    sig_detect_i = 1'b1;
    rate_detect_i = 1'b0;
    void'($urandom(94551));
    for (int k = 0; k < NUM_REGS; k++) sh[k] = REG_RST[k];
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk_cfg(cfg, exp_cfg());
    for (int k = 0; k < NUM_REGS; k++) rd_chk(REG_ADDR[k], REG_RST[k]);
    $display("test reset values done");
    for (int i = 0; i < 24; i++)
    begin
      slot_wr(codes[i][15:8], codes[i][7:0], 1'b1, 0);
      rd_chk(codes[i][15:8], sh[idx(codes[i][15:8])]);
    end
    $display("test documented codes done");
    slot_wr(ADDR_L1A_IDLE, 8'h22, 1'b1, 0);
    for (int j = 0; j < 4; j++)
    begin
      @(posedge clk_sys_i);
      sig_detect_i <= j[0];
      rate_detect_i <= j[1];
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk_cfg(cfg, exp_cfg());
    end
    $display("test automatic detection done");
    for (int k = 0; k < NUM_REGS; k++)
    begin
      slot_wr(REG_ADDR[k], 8'hff, 1'b0, 0);
      rd_chk(REG_ADDR[k], REG_WM[k]);
    end
    host.write_reg(8'h3e, 8'h5a, 1'b0, 0);
    rd_chk(8'h3e, RDATA_UNMAPPED);
    rd_chk(8'h36, RDATA_UNMAPPED);
    chk_cfg(cfg, exp_cfg());
    $display("test reserved bits and unmapped done");
    repeat (60)
    begin
      @(posedge clk_sys_i);
      sig_detect_i <= 1'($urandom_range(0, 1));
      rate_detect_i <= 1'($urandom_range(0, 1));
      slot_wr(REG_ADDR[$urandom_range(0, NUM_REGS - 1)], 8'($urandom), 1'b1,
        $urandom_range(3, 6));
      ra = REG_ADDR[$urandom_range(0, NUM_REGS - 1)];
      rd_chk(ra, sh[idx(ra)]);
    end
    $display("test random traffic done");
    report_and_stop();
  end
endmodule // test_lane_conditioning_config_regs
